// file: rfo_defs.vh
// constants for the raster format override control block
// Notes on behaviour
// - manual reset pin is active high
// - separate function select and read/write inputs
// - bit 5 of register 0Bh forces Flag_a
// - bits 4:0 sub-format; 33Fh picks generic HD
// - generic HD disables detection and EAV/SAV
// - no EAV/SAV means no line numbers, CRC
// - generic HD stops ancillary data insertion
// - port transfers timed by the master clock mclk, which also clocks the rest of the block
`ifndef RFO_DEFS_VH
`define RFO_DEFS_VH
`define RFO_ADDR_FORMAT   6'h0b
`define RFO_WORD_W        10
`define RFO_FLAG_A_BIT   5
`define RFO_SUBFMT_MSB    4
`define RFO_SUBFMT_LSB    0
`define RFO_GENERIC_WORD  10'h33f
`define RFO_GENERIC_SUB   5'h1f
`define RFO_FORMAT_RESET  10'h000
`define RFO_ADDR_W        6
`endif

// file: rfo_word_reg.v
// one stored control word with write strobe and reset default
module rfo_word_reg #(
	parameter [9:0] RESET_VAL = 10'h000
) (
	// clock and reset
	input  wire       clk,
	input  wire       rstn,
	// write side
	input  wire       wrEn,
	input  wire [9:0] wrData,
	// stored value
	output reg  [9:0] value_q
);
	// write lands on the port clock edge; reset gives the default
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			value_q <= RESET_VAL;
		end else if (wrEn) begin
			value_q <= wrData;
		end
	end
endmodule

// file: rfo_format_ctrl.v
// control port decoder and format register with derived mode outputs
`include "rfo_defs.vh"
module rfo_format_ctrl (
	// clock and resets
	input  wire        mclk,
	input  wire        rstn,
	input  wire        manualReset,
	// ancillary/control port
	input  wire        portFunctionSelect,
	input  wire        readNotWrite,
	input  wire [9:0]  adIn,
	output reg  [9:0]  adOut,
	output reg  [9:0]  adOe,
	// mode outputs toward the datapath
	output reg         flagA_q,
	output reg  [4:0]  subFormat_q,
	output reg         genericHd_q,
	output reg         trsDetectEn_q,
	output reg         eavSavGenEn_q,
	output reg         lineNumInsEn_q,
	output reg         crcInsEn_q,
	output reg         ancInsEn_q
);
	// control access: port function high selects control, addressing cycle
	// is a write whose bits 5:0 give the address; the next cycle carries data
	wire        ctrlSel;      // control access requested
	wire        doWrite;      // data phase write
	wire [9:0]  fmtValue;     // stored format word
	reg         addrValid_q;  // an address has been latched
	reg  [5:0]  addr_q;       // latched register address
	reg  [9:0]  outWord_d;    // read data selection

	assign ctrlSel = portFunctionSelect;

	// address phase: first control write after idle latches address
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addrValid_q <= 1'b0;
			addr_q      <= 6'h00;
		end else if (manualReset) begin
			addrValid_q <= 1'b0;
			addr_q      <= 6'h00;
		end else if (!ctrlSel) begin
			addrValid_q <= 1'b0; // leaving control mode aborts a pending access
		end else if (!addrValid_q && !readNotWrite) begin
			addrValid_q <= 1'b1;
			addr_q      <= adIn[5:0];
		end else if (addrValid_q) begin
			addrValid_q <= 1'b0; // one data phase per address phase
		end
	end

	// data phase write only to the format register address
	assign doWrite = ctrlSel && addrValid_q && !readNotWrite
		&& (addr_q == `RFO_ADDR_FORMAT) && !manualReset;

	// the manual reset acts as a synchronous clear; rstn is the async path
	wire regRstn;
	wire [9:0] wrWord;
	assign wrWord  = manualReset ? `RFO_FORMAT_RESET : adIn;
	assign regRstn = rstn;

	rfo_word_reg #(
		.RESET_VAL (`RFO_FORMAT_RESET)
	) uFormat (
		.clk     (mclk),
		.rstn    (regRstn),
		.wrEn    (doWrite | manualReset),
		.wrData  (wrWord),
		.value_q (fmtValue)
	);

	// read data: only the format register is mapped; others read zero
	always @* begin
		outWord_d = 10'h000;
		if (addr_q == `RFO_ADDR_FORMAT) begin
			outWord_d = fmtValue;
		end
	end

	// read drive: data port driven in the data phase of a control read
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			adOut <= 10'h000;
			adOe  <= 10'h000;
		end else if (ctrlSel && addrValid_q && readNotWrite && !manualReset) begin
			adOut <= outWord_d;
			adOe  <= 10'h3ff;
		end else begin
			adOut <= 10'h000;
			adOe  <= 10'h000;
		end
	end

	// mode decode: generic HD turns off detection and all insertion
	wire genericSel;
	assign genericSel = (fmtValue[`RFO_SUBFMT_MSB:`RFO_SUBFMT_LSB] == `RFO_GENERIC_SUB);

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flagA_q        <= 1'b0;
			subFormat_q    <= 5'h00;
			genericHd_q    <= 1'b0;
			trsDetectEn_q  <= 1'b1;
			eavSavGenEn_q  <= 1'b1;
			lineNumInsEn_q <= 1'b1;
			crcInsEn_q     <= 1'b1;
			ancInsEn_q     <= 1'b1;
		end else begin
			flagA_q        <= fmtValue[`RFO_FLAG_A_BIT];
			subFormat_q    <= fmtValue[`RFO_SUBFMT_MSB:`RFO_SUBFMT_LSB];
			genericHd_q    <= genericSel;
			trsDetectEn_q  <= !genericSel;
			eavSavGenEn_q  <= !genericSel;
			// line numbers and crc need the timing references to anchor on
			lineNumInsEn_q <= !genericSel;
			crcInsEn_q     <= !genericSel;
			// ancillary insertion keys off the same timing references; the
			// upstream source must carry crc and line numbers instead
			ancInsEn_q     <= !genericSel;
		end
	end
endmodule

// file: rfo_host.sv
// host controller model on the control port
module rfo_host (
	input  wire        c,
	input  wire  [9:0] q,
	output logic       s = 1'b0,
	output logic       w = 1'b0,
	output logic [9:0] d = 10'h000
);
	timeunit 1ns;
	timeprecision 1ps;
	// address phase then data phase, each launched on a falling edge
	// the video source behind this host supplies crc, line numbers
	// and field-ordered segmented-frame lines itself
	task automatic xfer(input [5:0] a, input [9:0] v, input r, output [9:0] o);
		@(negedge c);
		{s, w, d} = {2'b10, 4'h0, a};
		@(negedge c);
		{w, d} = {r, v};
		@(negedge c);
		o = q;
		// a released bus shows the inverse, never the held word
		{s, d} = {1'b0, ~v};
	endtask
endmodule

// file: rfo_format_chk.sv
// port checker for the format control block
module rfo_format_chk (
	input wire       mclk, rstn, manualReset, readNotWrite, flagA_q, genericHd_q,
	input wire       trsDetectEn_q, eavSavGenEn_q, lineNumInsEn_q, crcInsEn_q, ancInsEn_q,
	input wire [4:0] subFormat_q,
	input wire [9:0] adOe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_sub; genericHd_q |-> &subFormat_q; endproperty
	a_sub: assert property (p_sub) else $error("generic code");
	property p_trs; trsDetectEn_q != genericHd_q; endproperty
	a_trs: assert property (p_trs) else $error("detect");
	property p_eav; eavSavGenEn_q != genericHd_q; endproperty
	a_eav: assert property (p_eav) else $error("eav");
	property p_lin; lineNumInsEn_q == eavSavGenEn_q; endproperty
	a_lin: assert property (p_lin) else $error("line");
	property p_crc; crcInsEn_q == eavSavGenEn_q; endproperty
	a_crc: assert property (p_crc) else $error("crc");
	property p_anc; ancInsEn_q != genericHd_q; endproperty
	a_anc: assert property (p_anc) else $error("anc");
	property p_clr; manualReset |-> ##2 !flagA_q && !subFormat_q; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_rd; adOe != 10'h000 |-> $past(readNotWrite); endproperty
	a_rd: assert property (p_rd) else $error("drive");
endmodule
bind rfo_format_ctrl rfo_format_chk u_rfo_format_chk (.*);

// file: tb_top.sv
// self-checking bench for format control
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 1'b0, rstn = 1'b0, manualReset = 1'b0, flagA_q, genericHd_q;
	logic       portFunctionSelect, readNotWrite, trsDetectEn_q, eavSavGenEn_q;
	logic       lineNumInsEn_q, crcInsEn_q, ancInsEn_q;
	logic [4:0] subFormat_q;
	logic [9:0] adIn, adOut, adOe, q;
	int         failCount = 0, totalChecks = 0;
	rfo_host u_rfo_host (.c(mclk), .q(adOut), .s(portFunctionSelect), .w(readNotWrite), .d(adIn));
	rfo_format_ctrl u_rfo_format_ctrl (.*);
	task automatic cmp(string n, logic [9:0] e, g);
		totalChecks++;
		if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
		failCount += int'(g !== e);
	endtask
	// one access, then check the word xfer read, or the mode outputs one falling edge later
	task automatic op(input [5:0] a, input [9:0] d, input r, input [9:0] e);
		u_rfo_host.xfer(a, d, r, q);
		@(negedge mclk);
		cmp("port", r ? e : {3'h0, e[5:0], &e[4:0]},
			r ? q : {3'h0, flagA_q, subFormat_q, genericHd_q});
		if (!r) cmp("enables", {5'h00, {5{~&e[4:0]}}}, {5'h00, trsDetectEn_q,
			eavSavGenEn_q, lineNumInsEn_q, crcInsEn_q, ancInsEn_q});
	endtask
	task automatic endOfTest;
		$display("checks %0d fails %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial forever #20 mclk = ~mclk;
	initial begin
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		op(6'h0b, 10'h2aa, 1'b1, 10'h000);
		op(6'h0b, 10'h33f, 1'b0, 10'h33f);
		op(6'h0b, 10'h2aa, 1'b1, 10'h33f);
		op(6'h0c, 10'h3ff, 1'b0, 10'h33f);
		op(6'h0c, 10'h155, 1'b1, 10'h000);
		$display("access test done");
		manualReset = 1'b1;
		op(6'h0b, 10'h020, 1'b0, 10'h000);
		manualReset = 1'b0;
		op(6'h0b, 10'h020, 1'b0, 10'h020);
		$display("manual reset test done");
		endOfTest;
	end
endmodule
